// ==== rtl/drive_decode.sv ====
// Purpose: decodes switching frequency and signed advance angle
// Assumes: purely combinational
// Notes: angle in 0.12 degree counts and in hundredths of a degree
`timescale 1ns/10ps
`default_nettype none
module drive_decode
(
   input wire logic [4:0] freq_code_in,
   input wire logic sign_in,
   input wire logic [7:0] mag_in,
   output logic [6:0] pwm_khz_out,
   output logic signed [8:0] counts_out,
   output logic signed [12:0] centideg_out
);
   logic [6:0] low_idx;
   logic [11:0] prod;

   always_comb
   begin
      low_idx = {3'h0, freq_code_in[3:0]};
      if (freq_code_in[4])
      begin
         pwm_khz_out = speed_loop_pkg::PWM_HIGH_BASE_KHZ
                       + 7'(low_idx * speed_loop_pkg::PWM_HIGH_STEP_KHZ);
      end
      else
      begin
         pwm_khz_out = speed_loop_pkg::PWM_LOW_BASE_KHZ + low_idx;
      end
      prod = 12'({4'h0, mag_in} * speed_loop_pkg::ANGLE_CENTIDEG_PER_COUNT);
      if (sign_in)
      begin
         counts_out = $signed({1'b0, mag_in});
         centideg_out = $signed({1'b0, prod});
      end
      else
      begin
         counts_out = -$signed({1'b0, mag_in});
         centideg_out = -$signed({1'b0, prod});
      end
   end
endmodule : drive_decode
`default_nettype wire

// ==== rtl/ramp_rate_lut.sv ====
// Purpose: maps a five-bit ramp code to a slew rate in mV/s
// Assumes: purely combinational
// Notes: shared by ramp-up and ramp-down paths
`timescale 1ns/10ps
`default_nettype none
module ramp_rate_lut
(
   input wire logic [4:0] code_in,
   output logic [24:0] mvps_out
);
   always_comb
   begin
      case (code_in)
         5'h00: mvps_out = 25'h0000005;
         5'h01: mvps_out = 25'h000000a;
         5'h02: mvps_out = 25'h0000019;
         5'h03: mvps_out = 25'h0000032;
         5'h04: mvps_out = 25'h0000064;
         5'h05: mvps_out = 25'h00000fa;
         5'h06: mvps_out = 25'h00001f4;
         5'h07: mvps_out = 25'h00003e8;
         5'h08: mvps_out = 25'h00009c4;
         5'h09: mvps_out = 25'h0001388;
         5'h0a: mvps_out = 25'h0001d4c;
         5'h0b: mvps_out = 25'h0002710;
         5'h0c: mvps_out = 25'h00030d4;
         5'h0d: mvps_out = 25'h0003a98;
         5'h0e: mvps_out = 25'h0004e20;
         5'h0f: mvps_out = 25'h0007530;
         5'h10: mvps_out = 25'h0009c40;
         5'h11: mvps_out = 25'h000c350;
         5'h12: mvps_out = 25'h000ea60;
         5'h13: mvps_out = 25'h00124f8;
         5'h14: mvps_out = 25'h00186a0;
         5'h15: mvps_out = 25'h001e848;
         5'h16: mvps_out = 25'h00249f0;
         5'h17: mvps_out = 25'h002ab98;
         5'h18: mvps_out = 25'h0030d40;
         5'h19: mvps_out = 25'h003d090;
         5'h1a: mvps_out = 25'h00493e0;
         5'h1b: mvps_out = 25'h0061a80;
         5'h1c: mvps_out = 25'h007a120;
         5'h1d: mvps_out = 25'h00b71b0;
         5'h1e: mvps_out = 25'h00f4240;
         default: mvps_out = 25'h1f3fc18;
      endcase
   end
endmodule : ramp_rate_lut
`default_nettype wire

// ==== rtl/speed_loop_pkg.sv ====
// Purpose: shared constants and types for the speed loop settings register
// Assumes: 32-bit AXI4-Lite data, 12-bit byte addresses
// Notes: printed offset is a word index; byte address is four times it
package speed_loop_pkg;
   localparam int ADDR_W = 12;
   localparam logic [ADDR_W-1:0] SETTINGS_A_INDEX = 12'h086;
   localparam logic [ADDR_W-1:0] SETTINGS_A_ADDR = SETTINGS_A_INDEX << 2;
   localparam logic [31:0] SETTINGS_A_RESET = 32'h0000_0000;
   localparam logic [31:0] SETTINGS_A_WMASK = 32'hffff_fffe;
   localparam int PARITY_POS = 31;
   localparam int COMM_LSB = 29;
   localparam int UP_RATE_LSB = 24;
   localparam int DOWN_SRC_POS = 23;
   localparam int DOWN_RATE_LSB = 18;
   localparam int PWM_FREQ_LSB = 13;
   localparam int SIDE_LSB = 11;
   localparam int COMPL_POS = 10;
   localparam int SIGN_POS = 9;
   localparam int MAG_LSB = 1;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [6:0] PWM_LOW_BASE_KHZ = 7'h05;
   localparam logic [6:0] PWM_HIGH_BASE_KHZ = 7'h19;
   localparam logic [6:0] PWM_HIGH_STEP_KHZ = 7'h05;
   localparam logic [11:0] ANGLE_CENTIDEG_PER_COUNT = 12'h00c;

   typedef enum logic [1:0] {SIDE_HIGH, SIDE_LOW, SIDE_MIXED, SIDE_BAD} switch_side_e;
   typedef enum logic [1:0] {COMM_FIXED, COMM_VARIABLE, COMM_BAD2, COMM_BAD3} comm_width_e;

   typedef struct packed {
      logic [24:0] ramp_up_mvps;
      logic [24:0] ramp_down_mvps;
      logic [6:0] pwm_khz;
      switch_side_e switch_side;
      logic complementary;
      comm_width_e comm_width;
      logic signed [8:0] advance_counts;
      logic signed [12:0] advance_centideg;
      logic config_invalid;
      logic parity;
   } drive_cfg_s;
endpackage : speed_loop_pkg

// ==== rtl/speed_loop_settings.sv ====
// Purpose: AXI4-Lite settings register for closed-loop drive, with decoded fields
// Assumes: single clock, clk_in 100 MHz, rst_in async active high
// Notes: en_in low freezes all state, bus handshakes included
//
// How it works
// [RULE1] ramp-up code picks rate from table
// [RULE2] bit 23 selects ramp-down rate source
// [RULE3] ramp-down code uses same rate table
// [RULE4] frequency code maps to 5..100 kHz
// [RULE5] side select high, low, mixed; 3 invalid
// [RULE6] bit 10 selects complementary switching
// [RULE7] bit 9 sets advance angle sign
// [RULE8] advance magnitude is 0.12 degree counts
// [RULE9] commutation width fixed or variable; 2,3 invalid
// [RULE10] word at index 86h, resets to zero
// [RULE11] bit 0 reads zero, writes ignored
//
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module speed_loop_settings
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic en_in,
   input wire logic [11:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   input wire logic [11:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   output var speed_loop_pkg::drive_cfg_s cfg_out
);
   logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
   logic [11:0] awaddr_r, awaddr_nxt;
   logic [31:0] wdata_r, wdata_nxt;
   logic [3:0] wstrb_r, wstrb_nxt;
   logic awready_nxt, wready_nxt, bvalid_nxt, arready_nxt, rvalid_nxt;
   logic [1:0] bresp_nxt, rresp_nxt;
   logic [31:0] rdata_nxt;
   logic [31:0] settings_r, settings_nxt;
   logic [31:0] merged;
   logic aw_take, w_take, ar_take, wr_commit, wr_hit, rd_hit;
   speed_loop_pkg::drive_cfg_s cfg_nxt;
   logic [24:0] up_mvps, down_mvps;
   logic [6:0] pwm_khz;
   logic signed [8:0] adv_counts;
   logic signed [12:0] adv_centideg;

   // byte lanes merge write data over the held word
   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : lane
         assign merged[8*g +: 8] = wstrb_r[g] ? wdata_r[8*g +: 8] : settings_r[8*g +: 8];
      end
   endgenerate

   assign aw_take = s_axi_awvalid_in && s_axi_awready_out;
   assign w_take = s_axi_wvalid_in && s_axi_wready_out;
   assign ar_take = s_axi_arvalid_in && s_axi_arready_out;
   assign wr_commit = aw_held_r && w_held_r && !s_axi_bvalid_out;
   assign wr_hit = awaddr_r[11:2] == speed_loop_pkg::SETTINGS_A_ADDR[11:2];
   assign rd_hit = s_axi_araddr_in[11:2] == speed_loop_pkg::SETTINGS_A_ADDR[11:2];

   always_comb
   begin
      aw_held_nxt = aw_held_r;
      w_held_nxt = w_held_r;
      awaddr_nxt = awaddr_r;
      wdata_nxt = wdata_r;
      wstrb_nxt = wstrb_r;
      bvalid_nxt = s_axi_bvalid_out;
      bresp_nxt = s_axi_bresp_out;
      rvalid_nxt = s_axi_rvalid_out;
      rdata_nxt = s_axi_rdata_out;
      rresp_nxt = s_axi_rresp_out;
      settings_nxt = settings_r;
      if (aw_take)
      begin
         aw_held_nxt = 1'b1;
         awaddr_nxt = s_axi_awaddr_in;
      end
      if (w_take)
      begin
         w_held_nxt = 1'b1;
         wdata_nxt = s_axi_wdata_in;
         wstrb_nxt = s_axi_wstrb_in;
      end
      if (s_axi_bvalid_out && s_axi_bready_in)
      begin
         bvalid_nxt = 1'b0;
      end
      if (wr_commit)
      begin
         aw_held_nxt = 1'b0;
         w_held_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         if (wr_hit)
         begin
            settings_nxt = merged & speed_loop_pkg::SETTINGS_A_WMASK; // see [RULE11]
            bresp_nxt = speed_loop_pkg::RESP_OKAY;
         end
         else
         begin
            bresp_nxt = speed_loop_pkg::RESP_SLVERR;
         end
      end
      awready_nxt = !aw_held_nxt && !bvalid_nxt;
      wready_nxt = !w_held_nxt && !bvalid_nxt;
      if (s_axi_rvalid_out && s_axi_rready_in)
      begin
         rvalid_nxt = 1'b0;
      end
      if (ar_take)
      begin
         rvalid_nxt = 1'b1;
         if (rd_hit)
         begin
            rdata_nxt = settings_r & speed_loop_pkg::SETTINGS_A_WMASK; // see [RULE10]
            rresp_nxt = speed_loop_pkg::RESP_OKAY;
         end
         else
         begin
            rdata_nxt = 32'h0000_0000;
            rresp_nxt = speed_loop_pkg::RESP_SLVERR;
         end
      end
      arready_nxt = !rvalid_nxt;
   end

   ramp_rate_lut up_lut
   (
      .code_in(settings_r[speed_loop_pkg::UP_RATE_LSB +: 5]), // see [RULE1]
      .mvps_out(up_mvps)
   );

   ramp_rate_lut down_lut
   (
      .code_in(settings_r[speed_loop_pkg::DOWN_RATE_LSB +: 5]), // see [RULE3]
      .mvps_out(down_mvps)
   );

   drive_decode drv
   (
      .freq_code_in(settings_r[speed_loop_pkg::PWM_FREQ_LSB +: 5]), // see [RULE4]
      .sign_in(settings_r[speed_loop_pkg::SIGN_POS]), // see [RULE7]
      .mag_in(settings_r[speed_loop_pkg::MAG_LSB +: 8]), // see [RULE8]
      .pwm_khz_out(pwm_khz),
      .counts_out(adv_counts),
      .centideg_out(adv_centideg)
   );

   always_comb
   begin
      cfg_nxt.ramp_up_mvps = up_mvps;
      cfg_nxt.ramp_down_mvps = settings_r[speed_loop_pkg::DOWN_SRC_POS] ? up_mvps
                                                                      : down_mvps; // see [RULE2]
      cfg_nxt.pwm_khz = pwm_khz;
      cfg_nxt.switch_side = speed_loop_pkg::switch_side_e'(
                               settings_r[speed_loop_pkg::SIDE_LSB +: 2]); // see [RULE5]
      cfg_nxt.complementary = settings_r[speed_loop_pkg::COMPL_POS]; // see [RULE6]
      cfg_nxt.comm_width = speed_loop_pkg::comm_width_e'(
                              settings_r[speed_loop_pkg::COMM_LSB +: 2]); // see [RULE9]
      cfg_nxt.advance_counts = adv_counts;
      cfg_nxt.advance_centideg = adv_centideg;
      cfg_nxt.config_invalid = (settings_r[speed_loop_pkg::SIDE_LSB +: 2] == 2'h3)
                               || settings_r[speed_loop_pkg::COMM_LSB + 1]; // see [RULE5] [RULE9]
      cfg_nxt.parity = settings_r[speed_loop_pkg::PARITY_POS];
   end

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         awaddr_r <= 12'h000;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
         s_axi_awready_out <= 1'b0;
         s_axi_wready_out <= 1'b0;
         s_axi_bvalid_out <= 1'b0;
         s_axi_bresp_out <= 2'h0;
         s_axi_arready_out <= 1'b0;
         s_axi_rvalid_out <= 1'b0;
         s_axi_rdata_out <= 32'h0000_0000;
         s_axi_rresp_out <= 2'h0;
         settings_r <= speed_loop_pkg::SETTINGS_A_RESET; // see [RULE10]
         cfg_out <= '0;
      end
      else if (en_in)
      begin
         aw_held_r <= aw_held_nxt;
         w_held_r <= w_held_nxt;
         awaddr_r <= awaddr_nxt;
         wdata_r <= wdata_nxt;
         wstrb_r <= wstrb_nxt;
         s_axi_awready_out <= awready_nxt;
         s_axi_wready_out <= wready_nxt;
         s_axi_bvalid_out <= bvalid_nxt;
         s_axi_bresp_out <= bresp_nxt;
         s_axi_arready_out <= arready_nxt;
         s_axi_rvalid_out <= rvalid_nxt;
         s_axi_rdata_out <= rdata_nxt;
         s_axi_rresp_out <= rresp_nxt;
         settings_r <= settings_nxt;
         cfg_out <= cfg_nxt;
      end
   end

   sequence full_write_hit;
      en_in && wr_commit && wr_hit && (wstrb_r == 4'hf);
   endsequence

   sequence read_taken;
      en_in && ar_take && rd_hit;
   endsequence

   chk_up_rate_top: assert property (@(posedge clk_in) disable iff (rst_in) // see [RULE1]
      en_in && settings_r[28:24] == 5'h1f |=> cfg_out.ramp_up_mvps == 25'h1f3fc18)
      else $error("ramp-up top code rate wrong");

   chk_down_source_sel: assert property (@(posedge clk_in) disable iff (rst_in) // see [RULE2]
      en_in && settings_r[23] |=> cfg_out.ramp_down_mvps == cfg_out.ramp_up_mvps)
      else $error("ramp-down source select ignored");

   chk_down_rate_code1: assert property (@(posedge clk_in) disable iff (rst_in) // see [RULE3]
      en_in && !settings_r[23] && settings_r[22:18] == 5'h01
      |=> cfg_out.ramp_down_mvps == 25'h000000a)
      else $error("ramp-down code 1 rate wrong");

   chk_pwm_freq_map: assert property (@(posedge clk_in) disable iff (rst_in) // see [RULE4]
      en_in && !rst_in |=> cfg_out.pwm_khz == ($past(settings_r[17]) ? 7'h19 + 7'h05 *
                 7'($past(settings_r[16:13])) : 7'h05 + 7'($past(settings_r[16:13]))))
      else $error("switching frequency decode wrong");

   chk_side_invalid: assert property (@(posedge clk_in) disable iff (rst_in) // see [RULE5] [RULE9]
      en_in && (settings_r[12:11] == 2'h3 || settings_r[30]) |=> cfg_out.config_invalid)
      else $error("invalid setting not flagged");

   chk_compl_follow: assert property (@(posedge clk_in) disable iff (rst_in) // see [RULE6]
      en_in |=> cfg_out.complementary == $past(settings_r[10]))
      else $error("complementary select not applied");

   chk_advance_sign: assert property (@(posedge clk_in) disable iff (rst_in) // see [RULE7]
      en_in && !settings_r[9] && settings_r[8:1] != 8'h00 |=> cfg_out.advance_counts < 0)
      else $error("advance sign wrong");

   chk_advance_scale: assert property (@(posedge clk_in) disable iff (rst_in) // see [RULE8]
      en_in |=> cfg_out.advance_centideg == 13'(cfg_out.advance_counts * 13'sh00c))
      else $error("advance scaling wrong");

   chk_write_lands: assert property (@(posedge clk_in) disable iff (rst_in) // see [RULE10]
      full_write_hit |=> settings_r == ($past(wdata_r) & 32'hffff_fffe) && s_axi_bvalid_out)
      else $error("register write not stored");

   chk_read_returns: assert property (@(posedge clk_in) disable iff (rst_in) // see [RULE10]
      read_taken |=> s_axi_rvalid_out && s_axi_rdata_out == $past(settings_r))
      else $error("read data mismatch");

   chk_bit0_zero: assert property (@(posedge clk_in) disable iff (rst_in) // see [RULE11]
      s_axi_rvalid_out |-> !s_axi_rdata_out[0] && !settings_r[0])
      else $error("reserved bit not zero");

   chk_write_slverr: assert property (@(posedge clk_in) disable iff (rst_in) // see [RULE10]
      en_in && wr_commit && !wr_hit |=> s_axi_bresp_out == speed_loop_pkg::RESP_SLVERR
      && settings_r == $past(settings_r)) else $error("unmapped write not refused");

   chk_read_slverr: assert property (@(posedge clk_in) disable iff (rst_in) // see [RULE10]
      en_in && ar_take && !rd_hit |=> s_axi_rresp_out == speed_loop_pkg::RESP_SLVERR
      && s_axi_rdata_out == 32'h0000_0000) else $error("unmapped read not refused");

   chk_stall_freeze: assert property (@(posedge clk_in) disable iff (rst_in) // see [RULE10]
      !en_in |=> $stable(settings_r) && $stable(s_axi_bvalid_out) && $stable(cfg_out))
      else $error("state moved while enable low");

   chk_bvalid_hold: assert property (@(posedge clk_in) disable iff (rst_in) // see [RULE10]
      s_axi_bvalid_out && !(en_in && s_axi_bready_in) |=> s_axi_bvalid_out
      && $stable(s_axi_bresp_out)) else $error("write response dropped early");

   chk_rvalid_hold: assert property (@(posedge clk_in) disable iff (rst_in) // see [RULE10]
      s_axi_rvalid_out && !(en_in && s_axi_rready_in) |=> s_axi_rvalid_out
      && $stable(s_axi_rdata_out)) else $error("read data dropped early");

   chk_side_follow: assert property (@(posedge clk_in) disable iff (rst_in) // see [RULE5]
      en_in && !rst_in |=> cfg_out.switch_side == $past(settings_r[12:11]))
      else $error("switch side select not applied");

   chk_comm_follow: assert property (@(posedge clk_in) disable iff (rst_in) // see [RULE9]
      en_in && !rst_in |=> cfg_out.comm_width == $past(settings_r[30:29]))
      else $error("commutation width select not applied");
endmodule : speed_loop_settings
`default_nettype wire

// ==== tb/speed_loop_settings_bench.sv ====
// Purpose: self-checking bench for the speed loop settings register
// Assumes: AXI4-Lite master driven at rising edges, one request at a time
// Notes: expected decode worked out from field codes, not from design outputs
`timescale 1ns/10ps
`default_nettype none
module speed_loop_settings_bench;
   typedef struct packed {logic [31:0] wd; logic [31:0] rd;} row_s;
   localparam logic [11:0] REG_ADDR = 12'h218;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic en_in = 1'b1;
   logic [11:0] aw_addr = 12'h000;
   logic aw_valid = 1'b0;
   logic [31:0] w_data = 32'h0000_0000;
   logic [3:0] w_strb = 4'h0;
   logic w_valid = 1'b0;
   logic b_ready = 1'b0;
   logic [11:0] ar_addr = 12'h000;
   logic ar_valid = 1'b0;
   logic r_ready = 1'b0;
   logic aw_ready, w_ready, b_valid, ar_ready, r_valid;
   logic [1:0] b_resp, r_resp, resp;
   logic [31:0] r_data, rd, word;
   speed_loop_pkg::drive_cfg_s cfg;
   int err_total = 0;
   int n_checks = 0;
   logic [24:0] rate [32] = '{25'h5, 25'ha, 25'h19, 25'h32, 25'h64, 25'hfa, 25'h1f4, 25'h3e8,
      25'h9c4, 25'h1388, 25'h1d4c, 25'h2710, 25'h30d4, 25'h3a98, 25'h4e20, 25'h7530,
      25'h9c40, 25'hc350, 25'hea60, 25'h124f8, 25'h186a0, 25'h1e848, 25'h249f0, 25'h2ab98,
      25'h30d40, 25'h3d090, 25'h493e0, 25'h61a80, 25'h7a120, 25'hb71b0, 25'hf4240, 25'h1f3fc18};
   row_s rows [6] = '{'{32'h0000_0001, 32'h0000_0000}, '{32'h2080_1801, 32'h2080_1800},
      '{32'h4000_1000, 32'h4000_1000}, '{32'h6000_0800, 32'h6000_0800},
      '{32'h9f7e_07ff, 32'h9f7e_07fe}, '{32'hffff_ffff, 32'hffff_fffe}};

   speed_loop_settings uut
   (
      .clk_in(clk_in), .rst_in(rst_in), .en_in(en_in),
      .s_axi_awaddr_in(aw_addr), .s_axi_awvalid_in(aw_valid), .s_axi_awready_out(aw_ready),
      .s_axi_wdata_in(w_data), .s_axi_wstrb_in(w_strb), .s_axi_wvalid_in(w_valid),
      .s_axi_wready_out(w_ready), .s_axi_bresp_out(b_resp), .s_axi_bvalid_out(b_valid),
      .s_axi_bready_in(b_ready), .s_axi_araddr_in(ar_addr), .s_axi_arvalid_in(ar_valid),
      .s_axi_arready_out(ar_ready), .s_axi_rdata_out(r_data), .s_axi_rresp_out(r_resp),
      .s_axi_rvalid_out(r_valid), .s_axi_rready_in(r_ready), .cfg_out(cfg)
   );

   always #5 clk_in = ~clk_in;

   task automatic chk(input string name, input logic [127:0] exp, input logic [127:0] got);
      n_checks++;
      if (got !== exp)
      begin
         $display("ERROR %s expected %h seen %h", name, exp, got);
         err_total++;
      end
   endtask : chk

   function automatic speed_loop_pkg::drive_cfg_s exp_cfg(input logic [31:0] w);
      speed_loop_pkg::drive_cfg_s e;
      e.ramp_up_mvps = rate[w[28:24]];
      e.ramp_down_mvps = w[23] ? rate[w[28:24]] : rate[w[22:18]];
      e.pwm_khz = w[17] ? 7'h19 + 7'h05 * {3'h0, w[16:13]} : 7'h05 + {3'h0, w[16:13]};
      e.switch_side = speed_loop_pkg::switch_side_e'(w[12:11]);
      e.complementary = w[10];
      e.comm_width = speed_loop_pkg::comm_width_e'(w[30:29]);
      e.advance_counts = w[9] ? $signed({1'b0, w[8:1]}) : -$signed({1'b0, w[8:1]});
      e.advance_centideg = e.advance_counts * 13'sh00c;
      e.config_invalid = (w[12:11] == 2'h3) || w[30];
      e.parity = w[31];
      return e;
   endfunction : exp_cfg

   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
      output logic [1:0] r);
      int n;
      @(posedge clk_in);
      aw_addr <= a;
      aw_valid <= 1'b1;
      w_data <= d;
      w_strb <= s;
      w_valid <= 1'b1;
      b_ready <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk_in);
         if (aw_valid && aw_ready === 1'b1 && en_in) aw_valid <= 1'b0;
         if (w_valid && w_ready === 1'b1 && en_in) w_valid <= 1'b0;
         n++;
      end
      while (!(b_valid === 1'b1 && en_in) && n < 60);
      r = b_resp;
      b_ready <= 1'b0;
      if (n >= 60) chk("write_timeout", 128'h0, 128'h1);
   endtask : axi_wr

   task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge clk_in);
      ar_addr <= a;
      ar_valid <= 1'b1;
      r_ready <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk_in);
         if (ar_valid && ar_ready === 1'b1 && en_in) ar_valid <= 1'b0;
         n++;
      end
      while (!(r_valid === 1'b1 && en_in) && n < 60);
      d = r_data;
      r = r_resp;
      r_ready <= 1'b0;
      if (n >= 60) chk("read_timeout", 128'h0, 128'h1);
   endtask : axi_rd

   // write, read back and compare the decoded fields
   task automatic do_word(input logic [31:0] w, input logic [31:0] exp_rd);
      axi_wr(REG_ADDR, w, 4'hf, resp);
      chk("bresp", 128'(2'h0), 128'(resp));
      axi_rd(REG_ADDR, rd, resp);
      chk("rresp", 128'(2'h0), 128'(resp));
      chk("rdata", 128'(exp_rd), 128'(rd));
      #1;
      chk("cfg", 128'(exp_cfg(exp_rd)), 128'(cfg));
   endtask : do_word

   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : conclude

   initial
   begin
      repeat (20000) @(posedge clk_in);
      err_total++;
      conclude();
   end

   initial
   begin
      repeat (16) @(posedge clk_in);
      chk("cfg_in_reset", 128'h0, 128'(cfg));
      rst_in <= 1'b0;
      axi_rd(REG_ADDR, rd, resp);
      chk("reset_word", 128'h0, 128'(rd));
      #1;
      chk("reset_cfg", 128'(exp_cfg(32'h0)), 128'(cfg));
      foreach (rows[i]) do_word(rows[i].wd, rows[i].rd);
      // every table code, both signs, both ramp-down sources
      for (int i = 0; i < 32; i++)
      begin
         word = {1'b0, 2'(i % 2), 5'(i), 1'(i % 4 == 3), 5'(31 - i), 5'(i), 2'(i % 3),
            1'(i % 2), 1'(i % 2), 8'(i * 8 + 7), 1'b0};
         do_word(word, word);
      end
      do_word(32'h0000_0000, 32'h0000_0000);
      axi_wr(REG_ADDR, 32'hffff_ffff, 4'h5, resp);
      chk("strobe_bresp", 128'(2'h0), 128'(resp));
      axi_rd(REG_ADDR, rd, resp);
      chk("strobe_word", 128'(32'h00ff_00fe), 128'(rd));
      axi_wr(12'h21c, 32'h1234_5678, 4'hf, resp);
      chk("unmapped_bresp", 128'(2'h2), 128'(resp));
      axi_rd(REG_ADDR, rd, resp);
      chk("unmapped_nostore", 128'(32'h00ff_00fe), 128'(rd));
      axi_rd(12'h000, rd, resp);
      chk("unmapped_rresp", 128'(2'h2), 128'(resp));
      chk("unmapped_rdata", 128'h0, 128'(rd));
      // stall the bus with the enable low before a write starts
      @(posedge clk_in);
      en_in <= 1'b0;
      fork
         axi_wr(REG_ADDR, 32'h0100_0000, 4'hf, resp);
      join_none
      repeat (10) @(posedge clk_in);
      chk("stall_bvalid", 128'h0, 128'(b_valid));
      en_in <= 1'b1;
      wait fork;
      chk("stall_bresp", 128'(2'h0), 128'(resp));
      axi_rd(REG_ADDR, rd, resp);
      chk("stall_word", 128'(32'h0100_0000), 128'(rd));
      do_word(32'h1f00_0000, 32'h1f00_0000);
      @(posedge clk_in);
      rst_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      #1;
      chk("cfg_mid_reset", 128'h0, 128'(cfg));
      @(posedge clk_in);
      rst_in <= 1'b0;
      axi_rd(REG_ADDR, rd, resp);
      chk("rereset_word", 128'h0, 128'(rd));
      conclude();
   end
endmodule : speed_loop_settings_bench
`default_nettype wire
